/* design/tpc_map.svh */
/*
 constants for the two-phase pulse event counter: field values, reset values.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
`define TPC_CNT_W 16
`define TPC_CNT_MAX 16'hFFFF
`define TPC_CNT_RST 16'h0000
`define TPC_MODE_EVENT 2'h1
`define TPC_MULT_NORMAL 1'h0
`define TPC_MULT_BY4 1'h1
`define TPC_RUN_RELOAD 1'h0
`define TPC_RUN_FREE 1'h1
`endif

/* design/tpc_pkg.sv */
/*
 types for the two-phase pulse event counter.
 assumes tpc_map.svh is on the include path.
*/
`include "tpc_map.svh"
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_HOLD = 2'b00,
    TPC_UP = 2'b01,
    TPC_DOWN = 2'b10
  } tpc_dir_e;

  typedef struct packed {
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic a_prev;
    logic b_prev;
    logic [`TPC_CNT_W-1:0] count;
    logic [`TPC_CNT_W-1:0] reload;
    logic irq;
  } tpc_state_s;

  typedef struct packed {
    logic [1:0] mode;
    logic start;
    logic mult4;
    logic free_run;
  } tpc_cfg_s;
endpackage

/* design/tpc_counter.sv */
/*
 two-phase pulse event counter with reload register, normal and x4 decode.
 assumes phase pins are asynchronous; software ports are on clk.
*/
// Summary of operation
// - counts only from phase A and B pins
// - direction comes from phase relationship
// - reload from reload register on wrap
// - up overflow every FFFF minus n plus one
// - down underflow every n plus one
// - start flag one begins counting
// - start flag zero stops and holds
// - pulse interrupt on overflow or underflow
// - count value readable by software
// - stopped write loads reload and counter
// - running write loads reload only, and the counter too on a wrap in reload mode
// - normal: A edges count while B high
// - x4: up on all edges, up phase
// - x4: down on all edges, down phase
// - free-run wraps without reloading
// - mode field must be 01 to count
// - select bit: 0 normal, 1 x4
// - type bit: 0 reload, 1 free-run
`timescale 1ns/100ps
`include "tpc_map.svh"
module tpc_counter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic quad_phase_a_pin,
  input wire logic quad_phase_b_pin,
  input wire tpc_pkg::tpc_cfg_s cfg,
  input wire logic wr_en,
  input wire logic [`TPC_CNT_W-1:0] wr_data,
  output logic [`TPC_CNT_W-1:0] counter_value_register,
  output logic [`TPC_CNT_W-1:0] reload_value,
  output logic counter_irq
);
  tpc_pkg::tpc_state_s st_ff;
  tpc_pkg::tpc_state_s nxt_st;
  tpc_pkg::tpc_dir_e dir;
  logic a;
  logic b;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic running;
  logic wrap;

  assign a = st_ff.a_sync[1];
  assign b = st_ff.b_sync[1];
  assign a_rise = a & ~st_ff.a_prev;
  assign a_fall = ~a & st_ff.a_prev;
  assign b_rise = b & ~st_ff.b_prev;
  assign b_fall = ~b & st_ff.b_prev;
  assign running = cfg.start & (cfg.mode == `TPC_MODE_EVENT);

  // direction decode from phase relationship
  always_comb
  begin
    dir = tpc_pkg::TPC_HOLD;
    if (cfg.mult4 == `TPC_MULT_BY4)
    begin
      // up sequence: A rises with B high, B falls with A high, etc.
      if ((a_rise & b) | (b_fall & a) | (a_fall & ~b) | (b_rise & ~a))
        dir = tpc_pkg::TPC_UP;
      else if ((a_fall & b) | (b_rise & a) | (a_rise & ~b) | (b_fall & ~a))
        dir = tpc_pkg::TPC_DOWN;
    end
    else
    begin
      if (a_rise & b)
        dir = tpc_pkg::TPC_UP;
      else if (a_fall & b)
        dir = tpc_pkg::TPC_DOWN;
      // edges of A with B low fall through as hold
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.a_sync = {st_ff.a_sync[0], quad_phase_a_pin};
    nxt_st.b_sync = {st_ff.b_sync[0], quad_phase_b_pin};
    nxt_st.a_prev = a;
    nxt_st.b_prev = b;
    nxt_st.irq = 1'h0;
    wrap = 1'h0;
    if (wr_en)
    begin
      nxt_st.reload = wr_data;
      if (!running)
        nxt_st.count = wr_data;
    end
    if (running && dir != tpc_pkg::TPC_HOLD)
    begin
      case (dir)
        tpc_pkg::TPC_UP:
        begin
          wrap = (st_ff.count == `TPC_CNT_MAX);
          nxt_st.count = st_ff.count + 16'h0001;
        end
        tpc_pkg::TPC_DOWN:
        begin
          wrap = (st_ff.count == `TPC_CNT_RST);
          nxt_st.count = st_ff.count - 16'h0001;
        end
        default:
        begin
          wrap = 1'h0;
        end
      endcase
      if (wrap)
      begin
        nxt_st.irq = 1'h1;
        if (cfg.free_run == `TPC_RUN_RELOAD)
          nxt_st.count = wr_en ? wr_data : st_ff.reload;
        // free-run keeps the wrapped value
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign counter_value_register = st_ff.count;
  assign reload_value = st_ff.reload;
  assign counter_irq = st_ff.irq;

  // assertions
  a_stop_holds: assert property (@(posedge clk) disable iff (!rstn)
    (!running && !wr_en) |=> (st_ff.count == $past(st_ff.count)))
    else $error("count moved while stopped");
  a_stop_write: assert property (@(posedge clk) disable iff (!rstn)
    (!running && wr_en) |=> (st_ff.count == $past(wr_data) && st_ff.reload == $past(wr_data)))
    else $error("stopped write did not load both");
  a_run_write: assert property (@(posedge clk) disable iff (!rstn)
    (running && wr_en && dir == tpc_pkg::TPC_HOLD) |=>
      (st_ff.reload == $past(wr_data) && st_ff.count == $past(st_ff.count)))
    else $error("running write touched counter");
  a_up_step: assert property (@(posedge clk) disable iff (!rstn)
    (running && dir == tpc_pkg::TPC_UP && st_ff.count != `TPC_CNT_MAX) |=>
      (st_ff.count == $past(st_ff.count) + 16'h0001))
    else $error("up count wrong");
  a_down_step: assert property (@(posedge clk) disable iff (!rstn)
    (running && dir == tpc_pkg::TPC_DOWN && st_ff.count != `TPC_CNT_RST) |=>
      (st_ff.count == $past(st_ff.count) - 16'h0001))
    else $error("down count wrong");
  a_reload_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (wrap && cfg.free_run == `TPC_RUN_RELOAD && !wr_en) |=>
      (st_ff.count == $past(st_ff.reload) && counter_irq))
    else $error("reload on wrap missing");
  a_free_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (wrap && cfg.free_run == `TPC_RUN_FREE && dir == tpc_pkg::TPC_UP) |=>
      (st_ff.count == `TPC_CNT_RST))
    else $error("free-run did not wrap");
  a_irq_cause: assert property (@(posedge clk) disable iff (!rstn)
    counter_irq |-> $past(wrap && running))
    else $error("irq without wrap");
  a_normal_blow: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_NORMAL && !b) |-> dir == tpc_pkg::TPC_HOLD)
    else $error("count with phase B low");
  a_x4_up: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && b_fall && a && !a_rise && !a_fall) |->
      dir == tpc_pkg::TPC_UP)
    else $error("x4 up edge missed");

  // synchroniser and edge register checks
  a_sync_a_first: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.a_sync[0] == $past(quad_phase_a_pin)))
    else $error("phase a first flop wrong");
  a_sync_b_first: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.b_sync[0] == $past(quad_phase_b_pin)))
    else $error("phase b first flop wrong");
  a_sync_a_second: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.a_sync[1] == $past(st_ff.a_sync[0])))
    else $error("phase a second flop wrong");
  a_sync_b_second: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.b_sync[1] == $past(st_ff.b_sync[0])))
    else $error("phase b second flop wrong");
  a_prev_a_track: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.a_prev == $past(a)))
    else $error("phase a edge register wrong");
  a_prev_b_track: assert property (@(posedge clk) disable iff (!rstn)
    1'h1 |=>
      (st_ff.b_prev == $past(b)))
    else $error("phase b edge register wrong");

  // decode checks
  a_no_edge_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!a_rise && !a_fall && !b_rise && !b_fall) |->
      dir == tpc_pkg::TPC_HOLD)
    else $error("count without phase edge");
  a_norm_b_only: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_NORMAL && !a_rise && !a_fall) |->
      dir == tpc_pkg::TPC_HOLD)
    else $error("normal mode counted a b edge");
  a_norm_up: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_NORMAL && a_rise && b) |->
      dir == tpc_pkg::TPC_UP)
    else $error("normal up edge missed");
  a_norm_down: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_NORMAL && a_fall && b) |->
      dir == tpc_pkg::TPC_DOWN)
    else $error("normal down edge missed");
  a_x4_a_rise: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && a_rise && b) |->
      dir == tpc_pkg::TPC_UP)
    else $error("x4 up on a rise missed");
  a_x4_a_fall: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && a_fall && !b) |->
      dir == tpc_pkg::TPC_UP)
    else $error("x4 up on a fall missed");
  a_x4_b_rise: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && b_rise && !a && !a_rise && !a_fall) |->
      dir == tpc_pkg::TPC_UP)
    else $error("x4 up on b rise missed");
  a_x4_down_af: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && a_fall && b && !b_rise && !b_fall) |->
      dir == tpc_pkg::TPC_DOWN)
    else $error("x4 down on a fall missed");
  a_x4_down_br: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && b_rise && a && !a_rise && !a_fall) |->
      dir == tpc_pkg::TPC_DOWN)
    else $error("x4 down on b rise missed");
  a_x4_down_ar: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && a_rise && !b && !b_rise && !b_fall) |->
      dir == tpc_pkg::TPC_DOWN)
    else $error("x4 down on a rise missed");
  a_x4_down_bf: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mult4 == `TPC_MULT_BY4 && b_fall && !a && !a_rise && !a_fall) |->
      dir == tpc_pkg::TPC_DOWN)
    else $error("x4 down on b fall missed");

  // count and reload checks
  a_stop_no_irq: assert property (@(posedge clk) disable iff (!rstn)
    !running |=>
      !counter_irq)
    else $error("irq while stopped");
  a_mode_gate: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.mode != `TPC_MODE_EVENT && !wr_en) |=>
      (st_ff.count == $past(st_ff.count)))
    else $error("count moved outside event mode");
  a_wrap_irq: assert property (@(posedge clk) disable iff (!rstn)
    (running && wrap) |=>
      counter_irq)
    else $error("wrap without irq");
  a_run_reload: assert property (@(posedge clk) disable iff (!rstn)
    (running && wr_en) |=>
      (st_ff.reload == $past(wr_data)))
    else $error("running write missed reload");
  a_reload_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wr_en |=>
      (st_ff.reload == $past(st_ff.reload)))
    else $error("reload changed without write");
  a_wrap_write: assert property (@(posedge clk) disable iff (!rstn)
    (wrap && cfg.free_run == `TPC_RUN_RELOAD && wr_en) |=>
      (st_ff.count == $past(wr_data)))
    else $error("write on wrap not reloaded");
  a_free_under: assert property (@(posedge clk) disable iff (!rstn)
    (wrap && cfg.free_run == `TPC_RUN_FREE && dir == tpc_pkg::TPC_DOWN) |=>
      (st_ff.count == `TPC_CNT_MAX))
    else $error("free-run underflow did not wrap");
  a_up_end: assert property (@(posedge clk) disable iff (!rstn)
    (running && dir == tpc_pkg::TPC_UP && st_ff.count == `TPC_CNT_MAX) |->
      wrap)
    else $error("overflow not flagged");
  a_down_end: assert property (@(posedge clk) disable iff (!rstn)
    (running && dir == tpc_pkg::TPC_DOWN && st_ff.count == `TPC_CNT_RST) |->
      wrap)
    else $error("underflow not flagged");
  a_wrap_end: assert property (@(posedge clk) disable iff (!rstn)
    wrap |->
      ((st_ff.count == `TPC_CNT_MAX && dir == tpc_pkg::TPC_UP) ||
        (st_ff.count == `TPC_CNT_RST && dir == tpc_pkg::TPC_DOWN)))
    else $error("wrap away from count end");
  a_start_runs: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.start && cfg.mode == `TPC_MODE_EVENT && dir == tpc_pkg::TPC_UP && !wr_en) |=>
      (st_ff.count != $past(st_ff.count)))
    else $error("started counter did not count");

  c_up_wrap: cover property (@(posedge clk) disable iff (!rstn)
    wrap && dir == tpc_pkg::TPC_UP);
  c_down_wrap: cover property (@(posedge clk) disable iff (!rstn)
    wrap && dir == tpc_pkg::TPC_DOWN);
  c_x4_down: cover property (@(posedge clk) disable iff (!rstn)
    running && cfg.mult4 && dir == tpc_pkg::TPC_DOWN);
  c_run_write: cover property (@(posedge clk) disable iff (!rstn)
    running && wr_en);
  c_free_wrap: cover property (@(posedge clk) disable iff (!rstn)
    wrap && cfg.free_run == `TPC_RUN_FREE);
endmodule // tpc_counter

/* test/tpc_quad_src.sv */
/*
 quadrature pulse source model driving phase a and b.
 assumes clk is the counter clock.
*/
`timescale 1ns/100ps
module tpc_quad_src (
  input wire logic clk,
  output logic pa,
  output logic pb
);
  logic [1:0] seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int idx = 0;
  initial {pa, pb} = 2'h0;
  // gray steps, one pin at a time, each level held 5 clocks
  task automatic step(input logic up, input int n);
    repeat (n)
    begin
      idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
      @(posedge clk) {pa, pb} <= seq[idx];
      repeat (4) @(posedge clk);
    end
    #1;
  endtask
endmodule // tpc_quad_src

/* test/tb_tpc_counter.sv */
/*
 self-checking bench for tpc_counter.
 assumes 3-cycle pin latency and 1-cycle write latency.
*/
`timescale 1ns/100ps
module tb_tpc_counter;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic wr_en = 1'h0;
  logic [15:0] wr_data = 16'h0000;
  tpc_pkg::tpc_cfg_s cfg = '0;
  logic pa, pb, irq;
  logic [15:0] cnt, rld;
  int n_fail = 0;
  int checked = 0;
  int irqs = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (irq === 1'h1) irqs <= irqs + 1;
  tpc_quad_src tpc_quad_src_inst (.clk(clk), .pa(pa), .pb(pb));
  tpc_counter tpc_counter_inst (.clk(clk), .rstn(rstn), .quad_phase_a_pin(pa),
    .quad_phase_b_pin(pb), .cfg(cfg), .wr_en(wr_en), .wr_data(wr_data),
    .counter_value_register(cnt), .reload_value(rld), .counter_irq(irq));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk) wr_en <= 1'h1;
    wr_data <= d;
    @(posedge clk) wr_en <= 1'h0;
    @(posedge clk) #1;
  endtask
  // cfg bits: mode[4:3] start mult4 free_run
  task automatic cf(input logic [4:0] v);
    @(posedge clk) cfg <= v;
  endtask
  task automatic t_norm;
    cf(5'h08);
    chk(cnt, 16'h0000);
    wr(16'hFFFE);
    chk(cnt, 16'hFFFE);
    chk(rld, 16'hFFFE);
    cf(5'h0C);
    tpc_quad_src_inst.step(1'h1, 4);
    chk(cnt, 16'hFFFF);
    tpc_quad_src_inst.step(1'h1, 4);
    chk(cnt, 16'hFFFE);
    chk(16'(irqs), 16'h0001);
    tpc_quad_src_inst.step(1'h0, 4);
    chk(cnt, 16'hFFFD);
    wr(16'h1234);
    chk(rld, 16'h1234);
    chk(cnt, 16'hFFFD);
    $display("t_norm done");
  endtask
  task automatic t_x4;
    cf(5'h0A);
    wr(16'h0003);
    cf(5'h0E);
    tpc_quad_src_inst.step(1'h0, 4);
    chk(cnt, 16'h0003);
    chk(16'(irqs), 16'h0002);
    tpc_quad_src_inst.step(1'h1, 2);
    chk(cnt, 16'h0005);
    $display("t_x4 done");
  endtask
  task automatic t_free;
    cf(5'h0B);
    wr(16'h0001);
    cf(5'h0F);
    tpc_quad_src_inst.step(1'h0, 2);
    chk(cnt, 16'hFFFF);
    chk(16'(irqs), 16'h0003);
    cf(5'h0B);
    tpc_quad_src_inst.step(1'h1, 4);
    chk(cnt, 16'hFFFF);
    cf(5'h07);
    tpc_quad_src_inst.step(1'h1, 4);
    chk(cnt, 16'hFFFF);
    cf(5'h0F);
    tpc_quad_src_inst.step(1'h1, 1);
    chk(cnt, 16'h0000);
    $display("t_free done");
  endtask
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_fail++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    t_norm();
    t_x4();
    t_free();
    finish_test();
  end
endmodule // tb_tpc_counter
